// ### design/odsl_host.sv
`timescale 1ns/1ps
module odsl_host #(
   parameter int HALF_CYC = odsl_pkg::HALF_CYC,
   parameter int SETUP_CYC = odsl_pkg::SETUP_CYC,
   parameter int LOAD_CYC = odsl_pkg::LOAD_CYC,
   parameter int OUTPUT_UPDATE_STROBE_CYC = odsl_pkg::OUTPUT_UPDATE_STROBE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   odsl_if.host lnk,
   input wire logic wr_req,
   input wire logic [odsl_pkg::SEL_W-1:0] wr_sel,
   input wire logic wr_range,
   input wire logic [odsl_pkg::CODE_W-1:0] wr_code,
   input wire logic wr_split,
   input wire logic hold_update,
   input wire logic upd_req,
   output logic busy,
   output logic done
);

   // ==========================================================
   // Elaboration checks
   if (HALF_CYC < 1 || HALF_CYC > 255 || SETUP_CYC < 1 || SETUP_CYC > 255 ||
       LOAD_CYC < 1 || LOAD_CYC > 255 || OUTPUT_UPDATE_STROBE_CYC < 1 || OUTPUT_UPDATE_STROBE_CYC > 255) begin : g_bad
      $error("Timing counts must lie in 1 to 255");
   end

   // ==========================================================
   // Sequencer
   odsl_pkg::odsl_host_st_t state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [4:0] bit_r, bit_nxt;
   logic [15:0] word_r, word_nxt;
   logic sclk_r, sclk_nxt;
   logic sdata_r, sdata_nxt;
   logic frame_r, frame_nxt;
   logic update_r, update_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic [odsl_pkg::WORD_W-1:0] cmd;
   logic [15:0] cmd_align;
   logic cnt_zero;

   assign cmd = {wr_sel, wr_range, wr_code}; // [RL3]
   // Split form leads with padding that the device shifts out [RL14] [RL15]
   assign cmd_align = wr_split ? {{odsl_pkg::PAD_BITS{1'b0}}, cmd} : {cmd, 4'h0};
   assign cnt_zero = (cnt_r == 8'h00);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_zero ? cnt_r : cnt_r - 8'h01;
      bit_nxt = bit_r;
      word_nxt = word_r;
      sclk_nxt = sclk_r;
      sdata_nxt = sdata_r;
      frame_nxt = frame_r;
      update_nxt = update_r;
      done_nxt = 1'b0;
      case (state_r)
         odsl_pkg::ODSL_IDLE: begin
            update_nxt = hold_update; // [RL13]
            if (wr_req) begin
               word_nxt = cmd_align;
               bit_nxt = wr_split ? 5'(odsl_pkg::SPLIT_BITS) : 5'(odsl_pkg::WORD_W); // [RL2]
               sdata_nxt = cmd_align[15]; // [RL4]
               sclk_nxt = 1'b1;
               cnt_nxt = 8'(HALF_CYC - 1);
               state_nxt = odsl_pkg::ODSL_HIGH;
            end else if (upd_req) begin
               update_nxt = 1'b0; // [RL7]
               cnt_nxt = 8'(OUTPUT_UPDATE_STROBE_CYC - 1);
               state_nxt = odsl_pkg::ODSL_UPD;
            end
         end
         odsl_pkg::ODSL_HIGH: begin
            if (cnt_zero) begin
               sclk_nxt = 1'b0; // [RL1]
               cnt_nxt = 8'(HALF_CYC - 1);
               state_nxt = odsl_pkg::ODSL_LOW;
            end
         end
         odsl_pkg::ODSL_LOW: begin
            if (cnt_zero && bit_r == 5'h01) begin
               cnt_nxt = 8'(SETUP_CYC - 1);
               state_nxt = odsl_pkg::ODSL_GAP;
            end else if (cnt_zero) begin
               bit_nxt = bit_r - 5'h01;
               word_nxt = {word_r[14:0], 1'b0};
               sdata_nxt = word_r[14]; // [RL4]
               sclk_nxt = 1'b1;
               cnt_nxt = 8'(HALF_CYC - 1);
               state_nxt = odsl_pkg::ODSL_HIGH;
            end
         end
         odsl_pkg::ODSL_GAP: begin
            if (cnt_zero) begin
               frame_nxt = 1'b0; // [RL5]
               cnt_nxt = 8'(LOAD_CYC - 1);
               state_nxt = odsl_pkg::ODSL_LOAD;
            end
         end
         odsl_pkg::ODSL_LOAD: begin
            if (cnt_zero) begin
               frame_nxt = 1'b1;
               done_nxt = 1'b1;
               state_nxt = odsl_pkg::ODSL_IDLE;
            end
         end
         odsl_pkg::ODSL_UPD: begin
            if (cnt_zero) begin
               update_nxt = hold_update;
               done_nxt = 1'b1;
               state_nxt = odsl_pkg::ODSL_IDLE;
            end
         end
         default: begin
            state_nxt = odsl_pkg::ODSL_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != odsl_pkg::ODSL_IDLE);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= odsl_pkg::ODSL_IDLE;
         cnt_r <= 8'h00;
         bit_r <= 5'h00;
         word_r <= 16'h0000;
         sclk_r <= 1'b0;
         sdata_r <= 1'b0;
         frame_r <= 1'b1;
         update_r <= 1'b1;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         word_r <= word_nxt;
         sclk_r <= sclk_nxt;
         sdata_r <= sdata_nxt;
         frame_r <= frame_nxt;
         update_r <= update_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign lnk.sclk = sclk_r;
   assign lnk.sdata = sdata_r;
   assign lnk.frame = frame_r;
   assign lnk.output_update_strobe = update_r;
   assign busy = busy_r;
   assign done = done_r;

endmodule // odsl_host

// ### design/odsl_pkg.sv
package odsl_pkg;
   // ==========================================================
   // Command word layout
   localparam int WORD_W = 12;
   localparam int CODE_W = 8;
   localparam int SEL_W = 3;
   localparam int NCH = 8;
   localparam int SEL_MSB = 11;
   localparam int SEL_LSB = 9;
   localparam int RNG_POS = 8;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 0;
   localparam int LEVEL_W = CODE_W + 1;
   // ==========================================================
   // Values after reset
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic RNG_RST = 1'b0;
   localparam logic [1:0] PIN_IDLE = 2'h3;
   // ==========================================================
   // Split transfer: two bursts of eight clocks
   localparam int BURST_BITS = 8;
   localparam int SPLIT_BITS = 2 * BURST_BITS;
   localparam int PAD_BITS = SPLIT_BITS - WORD_W;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS = 50;
   localparam int T_LOAD_NS = 250;
   localparam int T_OUTPUT_UPDATE_STROBE_NS = 250;
   localparam int HALF_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_CYC = (T_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OUTPUT_UPDATE_STROBE_CYC = (T_OUTPUT_UPDATE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Host sequencer states
   typedef enum logic [2:0] {
      ODSL_IDLE,
      ODSL_HIGH,
      ODSL_LOW,
      ODSL_GAP,
      ODSL_LOAD,
      ODSL_UPD
   } odsl_host_st_t;
endpackage

// ### design/odsl_if.sv
`timescale 1ns/1ps
interface odsl_if;
   logic sclk;
   logic sdata;
   logic frame;
   logic output_update_strobe;
   modport dev (
      input sclk,
      input sdata,
      input frame,
      input output_update_strobe
   );
   modport host (
      output sclk,
      output sdata,
      output frame,
      output output_update_strobe
   );
endinterface

// ### design/odsl_dev.sv
// Notes on behaviour
// (RL1) Shift data on falling clock while frame high
// (RL2) Word is twelve bits: code, select, range
// (RL3) Order: select bits, range bit, code
// (RL4) Host sends most significant bit first
// (RL5) Frame low pulse latches word to channel
// (RL6) Update low: frame fall updates output now
// (RL7) Update high: outputs change only on fall
// (RL8) Select decoded binary, zero is first channel
// (RL9) Range bit stored; high doubles output span
// (RL10) Reset clears every channel code to zero
// (RL11) Output is reference times code/256 times range
// (RL12) Low four channels first reference, rest second
// (RL13) All channels double buffered, common update
// (RL14) Word may arrive as two eight-clock bursts
// (RL15) Extra bits: only last twelve are kept
`timescale 1ns/1ps
module odsl_dev #(
   parameter int NCH = odsl_pkg::NCH
) (
   input wire logic clk,
   input wire logic srst,
   odsl_if.dev lnk,
   output logic [NCH-1:0][odsl_pkg::CODE_W-1:0] chan_code,
   output logic [NCH-1:0] chan_range_double,
   output logic [NCH-1:0][odsl_pkg::LEVEL_W-1:0] chan_level,
   output logic [NCH-1:0] chan_ref_high_group,
   output logic [NCH-1:0][odsl_pkg::CODE_W-1:0] chan_pending_code,
   output logic frame_seen
);

   // ==========================================================
   // Elaboration checks
   if (NCH != (1 << odsl_pkg::SEL_W)) begin : g_bad_nch
      $error("Channel count must match the select field");
   end

   // ==========================================================
   // Link domain: input shift register
   logic [odsl_pkg::WORD_W-1:0] shift_r;

   always_ff @(negedge lnk.sclk) begin
      if (lnk.frame) begin
         shift_r <= {shift_r[odsl_pkg::WORD_W-2:0], lnk.sdata}; // [RL1] [RL4] [RL14] [RL15]
      end
   end

   // ==========================================================
   // Strobe synchronisers (bit 0 frame, bit 1 update)
   logic [1:0] pin_raw;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] sync3_r;
   logic [1:0] filt_r;
   logic [1:0] filt_nxt;
   logic [1:0] agree;
   logic [1:0] pin_fall;

   assign pin_raw = {lnk.output_update_strobe, lnk.frame};

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= odsl_pkg::PIN_IDLE;
         sync2_r <= odsl_pkg::PIN_IDLE;
         sync3_r <= odsl_pkg::PIN_IDLE;
      end else begin
         sync1_r <= pin_raw;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign agree = ~(sync2_r ^ sync3_r);
   assign filt_nxt = (agree & sync2_r) | (~agree & filt_r);
   assign pin_fall = filt_r & ~filt_nxt;

   always_ff @(posedge clk) begin
      if (srst) begin
         filt_r <= odsl_pkg::PIN_IDLE;
      end else begin
         filt_r <= filt_nxt;
      end
   end

   // ==========================================================
   // Word fields and decode
   logic frame_fall;
   logic upd_fall;
   logic upd_low;
   logic [odsl_pkg::SEL_W-1:0] word_sel;
   logic word_rng;
   logic [odsl_pkg::CODE_W-1:0] word_code;
   logic [NCH-1:0] sel_hit;

   // Shift register is quiet while frame is low, so it is read here
   assign frame_fall = pin_fall[0]; // [RL5]
   assign upd_fall = pin_fall[1]; // [RL7]
   assign upd_low = ~filt_nxt[1];
   assign word_sel = shift_r[odsl_pkg::SEL_MSB:odsl_pkg::SEL_LSB]; // [RL2] [RL3]
   assign word_rng = shift_r[odsl_pkg::RNG_POS]; // [RL3] [RL9]
   assign word_code = shift_r[odsl_pkg::CODE_MSB:odsl_pkg::CODE_LSB]; // [RL3]

   // ==========================================================
   // Per-channel holding and output latches
   logic [NCH-1:0][odsl_pkg::CODE_W-1:0] hold_code_r;
   logic [NCH-1:0] hold_rng_r;
   logic [NCH-1:0][odsl_pkg::CODE_W-1:0] hold_code_nxt;
   logic [NCH-1:0] hold_rng_nxt;
   logic [NCH-1:0][odsl_pkg::CODE_W-1:0] out_code_r;
   logic [NCH-1:0] out_rng_r;
   logic [NCH-1:0][odsl_pkg::CODE_W-1:0] out_code_nxt;
   logic [NCH-1:0] out_rng_nxt;
   logic [NCH-1:0][odsl_pkg::LEVEL_W-1:0] level_r;
   logic [NCH-1:0][odsl_pkg::LEVEL_W-1:0] level_nxt;
   logic [NCH-1:0] ref_high_r;
   logic [NCH-1:0] hold_wr;
   logic [NCH-1:0] out_direct;

   for (genvar i = 0; i < NCH; i++) begin : g_chan
      assign sel_hit[i] = (word_sel == odsl_pkg::SEL_W'(i)); // [RL8]
      assign hold_wr[i] = frame_fall & sel_hit[i]; // [RL5]
      assign out_direct[i] = hold_wr[i] & upd_low; // [RL6]

      assign hold_code_nxt[i] = hold_wr[i] ? word_code : hold_code_r[i];
      assign hold_rng_nxt[i] = hold_wr[i] ? word_rng : hold_rng_r[i]; // [RL9]

      // New word wins over a simultaneous update of older contents
      assign out_code_nxt[i] = out_direct[i] ? word_code :
                               upd_fall ? hold_code_r[i] : out_code_r[i]; // [RL7] [RL13]
      assign out_rng_nxt[i] = out_direct[i] ? word_rng :
                              upd_fall ? hold_rng_r[i] : out_rng_r[i]; // [RL7] [RL13]

      // Scaled level in units of reference/256
      assign level_nxt[i] = out_rng_nxt[i] ? {out_code_nxt[i], 1'b0} :
                            {1'b0, out_code_nxt[i]}; // [RL11]
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hold_code_r <= {NCH{odsl_pkg::CODE_RST}}; // [RL10]
         hold_rng_r <= {NCH{odsl_pkg::RNG_RST}};
      end else begin
         hold_code_r <= hold_code_nxt;
         hold_rng_r <= hold_rng_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         out_code_r <= {NCH{odsl_pkg::CODE_RST}}; // [RL10]
         out_rng_r <= {NCH{odsl_pkg::RNG_RST}};
      end else begin
         out_code_r <= out_code_nxt;
         out_rng_r <= out_rng_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         level_r <= '0; // [RL10]
      end else begin
         level_r <= level_nxt;
      end
   end

   // ==========================================================
   // Reference group of each channel
   logic [NCH-1:0] ref_high_map;

   for (genvar j = 0; j < NCH; j++) begin : g_ref
      assign ref_high_map[j] = (j >= NCH / 2); // [RL12]
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ref_high_r <= '0;
      end else begin
         ref_high_r <= ref_high_map; // [RL12]
      end
   end

   // ==========================================================
   // Frame event flag
   logic frame_seen_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         frame_seen_r <= 1'b0;
      end else begin
         frame_seen_r <= frame_fall;
      end
   end

   // ==========================================================
   // Outputs
   assign chan_code = out_code_r;
   assign chan_range_double = out_rng_r;
   assign chan_level = level_r;
   assign chan_ref_high_group = ref_high_r;
   assign chan_pending_code = hold_code_r;
   assign frame_seen = frame_seen_r;

endmodule // odsl_dev

// ### dv/odsl_props.sv
`timescale 1ns/1ps
module odsl_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic frame,
   input wire logic output_update_strobe
);
   // ==========================================================
   // Helper counters
   logic [7:0] lo_cnt_r;
   logic [7:0] lo_cnt_nxt;
   logic [4:0] bit_cnt_r;
   logic [4:0] bit_cnt_nxt;
   logic sclk_r;
   wire logic sclk_fall;
   assign sclk_fall = sclk_r & ~sclk;
   assign lo_cnt_nxt = frame ? 8'h00 : lo_cnt_r + 8'h01;
   assign bit_cnt_nxt = !frame ? 5'h00 : bit_cnt_r + {4'h0, sclk_fall};
   always_ff @(posedge clk) begin
      if (srst) begin
         lo_cnt_r <= 8'h00;
         bit_cnt_r <= 5'h00;
         sclk_r <= 1'b0;
      end else begin
         lo_cnt_r <= lo_cnt_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         sclk_r <= sclk;
      end
   end
   // ==========================================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_sclk_still; !frame |-> !sclk; endproperty
   a_sclk_still: assert property (p_sclk_still) else $error("Serial clock active with frame low");
   property p_frame_len; $rose(frame) |-> lo_cnt_r == 8'h19; endproperty
   a_frame_len: assert property (p_frame_len) else $error("Frame low pulse length wrong");
   property p_bits; $fell(frame) |-> bit_cnt_r == 5'h0c || bit_cnt_r == 5'h10; endproperty
   a_bits: assert property (p_bits) else $error("Bit count per word wrong");
   property p_sclk_hi; $rose(sclk) |-> sclk [*5] ##1 !sclk; endproperty
   a_sclk_hi: assert property (p_sclk_hi) else $error("Serial clock high phase wrong");
   property p_sclk_lo; $fell(sclk) |-> !sclk [*5]; endproperty
   a_sclk_lo: assert property (p_sclk_lo) else $error("Serial clock low phase short");
   property p_load_setup; $fell(frame) |-> !$past(sclk) && !$past(sclk, 4); endproperty
   a_load_setup: assert property (p_load_setup) else $error("Frame fell too soon after last clock");
   property p_data_fall; $fell(sclk) |-> $stable(sdata); endproperty
   a_data_fall: assert property (p_data_fall) else $error("Data changed at clock fall");
   property p_data_hi; sclk && $past(sclk) |-> $stable(sdata); endproperty
   a_data_hi: assert property (p_data_hi) else $error("Data changed in clock high phase");
   property p_upd_frame; $fell(output_update_strobe) |-> frame; endproperty
   a_upd_frame: assert property (p_upd_frame) else $error("Update fell while frame low");
   property p_upd_len; $fell(output_update_strobe) |=> !output_update_strobe [*8]; endproperty
   a_upd_len: assert property (p_upd_len) else $error("Update low pulse short");
   // ==========================================================
   // Coverage
   c_split: cover property ($fell(frame) && bit_cnt_r == 5'h10);
   c_direct: cover property ($fell(frame) && !output_update_strobe);
   c_update: cover property ($fell(output_update_strobe));
endmodule // odsl_props

// ### dv/test_octal_dac_serial_loader.sv
`timescale 1ns/1ps
module test_octal_dac_serial_loader;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] wr_sel = 3'h0;
   logic [7:0] wr_code = 8'h00;
   logic wr_req = 1'b0, wr_range = 1'b0, wr_split = 1'b0, hold_update = 1'b1, upd_req = 1'b0;
   logic busy, done, frame_seen;
   logic [7:0][7:0] chan_code, chan_pending_code;
   logic [7:0][8:0] chan_level;
   logic [7:0] chan_range_double, chan_ref_high_group;
   logic [7:0][7:0] e_code = '0, e_pend = '0;
   logic [7:0] e_rng = '0, e_prng = '0;
   logic [31:0] r;
   int err_total = 0, checks_done = 0, seed = 95626, fs_cnt = 0, n_wr = 0;
   always #5 clk = ~clk;
   odsl_if odsl_if_i ();
   odsl_host odsl_host_i (.clk(clk), .srst(srst), .lnk(odsl_if_i.host), .wr_req(wr_req), .wr_sel(wr_sel),
      .wr_range(wr_range), .wr_code(wr_code), .wr_split(wr_split), .hold_update(hold_update),
      .upd_req(upd_req), .busy(busy), .done(done));
   odsl_dev odsl_dev_i (.clk(clk), .srst(srst), .lnk(odsl_if_i.dev), .chan_code(chan_code),
      .chan_range_double(chan_range_double), .chan_level(chan_level), .chan_ref_high_group(chan_ref_high_group),
      .chan_pending_code(chan_pending_code), .frame_seen(frame_seen));
   odsl_props odsl_props_i (.clk(clk), .srst(srst), .sclk(odsl_if_i.sclk), .sdata(odsl_if_i.sdata),
      .frame(odsl_if_i.frame), .output_update_strobe(odsl_if_i.output_update_strobe));
   always @(posedge clk) if (frame_seen === 1'b1) fs_cnt++;
   // ==========================================================
   // Checking
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [8:0] lvl(input logic [7:0] c, input logic g);
      return g ? {c, 1'b0} : {1'b0, c};
   endfunction
   task automatic chk_all();
      for (int i = 0; i < 8; i++) begin
         chk({8'h00, chan_code[i]}, {8'h00, e_code[i]});
         chk({15'h0000, chan_range_double[i]}, {15'h0000, e_rng[i]});
         chk({7'h00, chan_level[i]}, {7'h00, lvl(e_code[i], e_rng[i])});
         chk({15'h0000, chan_ref_high_group[i]}, {15'h0000, i > 3});
         chk({8'h00, chan_pending_code[i]}, {8'h00, e_pend[i]});
      end
   endtask
   task automatic complete_run();
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ==========================================================
   // Host request: write when w is high, update pulse otherwise
   task automatic op(input logic w, input logic [2:0] s, input logic g, input logic [7:0] c, input logic sp);
      int n;
      n = 0;
      @(negedge clk);
      wr_req = w;
      upd_req = !w;
      wr_sel = s;
      wr_range = g;
      wr_code = c;
      wr_split = sp;
      @(negedge clk);
      wr_req = 1'b0;
      upd_req = 1'b0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({15'h0000, done}, 16'h0001);
      if (w) begin
         n_wr++;
         e_pend[s] = c;
         e_prng[s] = g;
         if (!hold_update) begin
            e_code[s] = c;
            e_rng[s] = g;
         end
      end else begin
         e_code = e_pend;
         e_rng = e_prng;
      end
      repeat (6) @(negedge clk);
      chk_all();
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      chk_all();
      for (int k = 0; k < 3; k++) begin
         for (int ch = 0; ch < 8; ch++) begin
            r = $random(seed);
            op(1'b1, 3'(ch) ^ 3'(k * 3), ch == 0 ? 1'b1 : r[8], ch == 0 ? 8'hff : ch == 7 ? 8'h00 : r[7:0],
               r[9]);
         end
         if (k == 0) op(1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
         if (k == 1) begin
            @(negedge clk);
            hold_update = 1'b0;
            e_code = e_pend;
            e_rng = e_prng;
            repeat (8) @(negedge clk);
            chk_all();
         end
      end
      chk(fs_cnt[15:0], n_wr[15:0]);
      complete_run();
   end
   initial begin
      #400000;
      err_total++;
      complete_run();
   end
endmodule // test_octal_dac_serial_loader
